// >>> src/gpas_pkg.sv
// Package of offsets, field positions, reset values and codes for gpas.
package gpas_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the AXI4-Lite bus.
	// ----------------------------------------------------------------
	localparam int GPAS_AW = 8;
	localparam logic [7:0] GPAS_OFS_COND = 8'h00;
	localparam logic [7:0] GPAS_OFS_MODE = 8'h04;
	localparam logic [7:0] GPAS_OFS_ADDR = 8'h08;
	localparam logic [7:0] GPAS_OFS_AUX = 8'h0c;
	localparam logic [7:0] GPAS_OFS_LEGA = 8'h10;
	localparam logic [7:0] GPAS_OFS_LEGB = 8'h14;

	// ----------------------------------------------------------------
	// Address mode register fields and reset value.
	// ----------------------------------------------------------------
	localparam int GPAS_MODE_AM_LSB = 0;
	localparam int GPAS_MODE_LON = 2;
	localparam int GPAS_MODE_TON = 3;
	localparam int GPAS_MODE_COMPAT = 4;
	localparam logic [4:0] GPAS_MODE_RST = 5'h00;
	localparam logic [1:0] GPAS_AM_SINGLE = 2'h0;
	localparam logic [1:0] GPAS_AM_EXT_SINGLE = 2'h1;
	localparam logic [1:0] GPAS_AM_DUAL = 2'h2;
	localparam logic [1:0] GPAS_AM_EXT_DUAL = 2'h3;

	// ----------------------------------------------------------------
	// Own address register fields and reset value.
	// ----------------------------------------------------------------
	localparam int GPAS_ADDR_MAJ_LSB = 0;
	localparam int GPAS_ADDR_MIN_LSB = 8;
	localparam logic [4:0] GPAS_ADDR_RST = 5'h00;

	// ----------------------------------------------------------------
	// Auxiliary command bits, each a one-shot on write.
	// ----------------------------------------------------------------
	localparam int GPAS_AUX_LUL = 0;
	localparam int GPAS_AUX_LUT = 1;
	localparam int GPAS_AUX_CHRST = 2;

	// ----------------------------------------------------------------
	// GPIB command codes: two-bit group codes and seven-bit command bytes.
	// ----------------------------------------------------------------
	localparam logic [1:0] GPAS_GRP_LISTEN = 2'h1;
	localparam logic [1:0] GPAS_GRP_TALK = 2'h2;
	localparam logic [6:0] GPAS_CMD_UNL = 7'h3f;
	localparam logic [6:0] GPAS_CMD_UNT = 7'h5f;

	// ----------------------------------------------------------------
	// AXI response codes.
	// ----------------------------------------------------------------
	localparam logic [1:0] GPAS_RESP_OKAY = 2'h0;
	localparam logic [1:0] GPAS_RESP_SLVERR = 2'h2;

endpackage

// >>> src/gpas_status.sv
// Address status register bank of a GPIB interface, AXI4-Lite slave.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// --------------------------------------------------------------------
// --------------------------------------------------------------------
module gpas_status (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [gpas_pkg::GPAS_AW-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [gpas_pkg::GPAS_AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	output logic s_axi_rready_unused_out,
	input wire logic s_axi_rready_in,
	input wire logic atn_in,
	input wire logic ifc_in,
	input wire logic acds_in,
	input wire logic [7:0] cmd_byte_in,
	input wire logic serial_poll_active_in,
	input wire logic serial_poll_mode_in,
	input wire logic host_controlled_in,
	input wire logic lockout_in,
	output logic listener_active_out,
	output logic transmitter_role_active_out
);
	import gpas_pkg::*;

	// ----------------------------------------------------------------
	// State of the block.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [GPAS_AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [4:0] mode;
		logic [4:0] maj_addr;
		logic [4:0] min_addr;
		logic listen_primary_addressed;
		logic speaker_primary_addressed;
		logic la;
		logic ta;
		logic major_minor_select;
		logic ulpa;
		logic atn;
		logic spas;
		logic la_out;
		logic ta_out;
	} gpas_state_s;

	gpas_state_s state_reg;
	gpas_state_s state_next;

	logic [6:0] cb;
	logic cmd_ok;
	logic dual;
	logic is_pcg;
	logic listen_grp;
	logic talk_grp;
	logic mla_maj;
	logic mla_min;
	logic mta_maj;
	logic mta_min;
	logic mla;
	logic mta;
	logic [7:0] layout_a;
	logic [7:0] layout_b;
	logic wr_fire;
	logic mode_wr;
	logic aux_wr;

	// ----------------------------------------------------------------
	// Command decode of bytes accepted under ATN.
	// ----------------------------------------------------------------

	// Decode own listen and talk addresses, major and minor.
	always_comb begin
		cb = cmd_byte_in[6:0];
		cmd_ok = acds_in & atn_in;
		dual = (state_reg.mode[GPAS_MODE_AM_LSB +: 2] == GPAS_AM_DUAL) |
			(state_reg.mode[GPAS_MODE_AM_LSB +: 2] == GPAS_AM_EXT_DUAL);
		listen_grp = (cb[6:5] == GPAS_GRP_LISTEN);
		talk_grp = (cb[6:5] == GPAS_GRP_TALK);
		is_pcg = listen_grp | talk_grp;
		mla_maj = listen_grp & (cb != GPAS_CMD_UNL) &
			(cb[4:0] == state_reg.maj_addr);
		mla_min = dual & listen_grp & (cb != GPAS_CMD_UNL) &
			(cb[4:0] == state_reg.min_addr);
		mta_maj = talk_grp & (cb != GPAS_CMD_UNT) &
			(cb[4:0] == state_reg.maj_addr);
		mta_min = dual & talk_grp & (cb != GPAS_CMD_UNT) &
			(cb[4:0] == state_reg.min_addr);
		mla = mla_maj | mla_min;
		mta = mta_maj | mta_min;
	end

	// ----------------------------------------------------------------
	// Read layouts.
	// ----------------------------------------------------------------

	// Build both status byte layouts from the current state and the poll mode, host and lockout inputs.
	always_comb begin
		layout_a[7] = 1'b0;
		layout_a[6] = ~state_reg.atn;
		layout_a[5] = serial_poll_mode_in;
		layout_a[4] = state_reg.listen_primary_addressed;
		layout_a[3] = state_reg.speaker_primary_addressed;
		layout_a[2] = state_reg.la;
		layout_a[1] = state_reg.ta | state_reg.spas;
		layout_a[0] = state_reg.major_minor_select & dual;
		layout_b[7] = host_controlled_in;
		layout_b[6] = lockout_in;
		layout_b[5] = state_reg.atn;
		layout_b[4] = state_reg.listen_primary_addressed;
		layout_b[3] = state_reg.speaker_primary_addressed;
		layout_b[2] = state_reg.la;
		layout_b[1] = state_reg.ta | state_reg.spas;
		layout_b[0] = state_reg.ulpa;
	end

	// ----------------------------------------------------------------
	// Next state.
	// ----------------------------------------------------------------

	// Bus slave, configuration writes and address state tracking.
	always_comb begin
		state_next = state_reg;
		state_next.atn = atn_in;
		state_next.spas = serial_poll_active_in;

		// Write address and data are taken in either order.
		if (s_axi_awvalid_in && state_reg.awready) begin
			state_next.aw_got = 1'b1;
			state_next.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && state_reg.wready) begin
			state_next.w_got = 1'b1;
			state_next.wdata = s_axi_wdata_in;
			state_next.wstrb = s_axi_wstrb_in;
		end
		wr_fire = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;
		mode_wr = wr_fire & (state_reg.awaddr == GPAS_OFS_MODE) &
			state_reg.wstrb[0];
		aux_wr = wr_fire & (state_reg.awaddr == GPAS_OFS_AUX) &
			state_reg.wstrb[0];
		if (wr_fire) begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = GPAS_RESP_OKAY;
			case (state_reg.awaddr)
				GPAS_OFS_MODE: begin
					if (state_reg.wstrb[0]) begin
						state_next.mode = state_reg.wdata[4:0];
					end
				end
				GPAS_OFS_ADDR: begin
					if (state_reg.wstrb[0]) begin
						state_next.maj_addr = state_reg.wdata[4:0];
					end
					if (state_reg.wstrb[1]) begin
						state_next.min_addr = state_reg.wdata[12:8];
					end
				end
				GPAS_OFS_AUX, GPAS_OFS_COND, GPAS_OFS_LEGA,
				GPAS_OFS_LEGB: begin
					state_next.bresp = GPAS_RESP_OKAY;
				end
				default: begin
					state_next.bresp = GPAS_RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.bvalid && s_axi_bready_in) begin
			state_next.bvalid = 1'b0;
		end
		state_next.awready = ~state_next.aw_got & ~state_next.bvalid;
		state_next.wready = ~state_next.w_got & ~state_next.bvalid;

		// Read channel answers one cycle after the address is taken.
		if (s_axi_rready_in && state_reg.rvalid) begin
			state_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && state_reg.arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = GPAS_RESP_OKAY;
			state_next.rdata = 32'h0000_0000;
			case (s_axi_araddr_in)
				GPAS_OFS_COND: begin
					state_next.rdata[7:0] =
						state_reg.mode[GPAS_MODE_COMPAT] ?
						layout_b : layout_a;
				end
				GPAS_OFS_MODE: begin
					state_next.rdata[4:0] = state_reg.mode;
				end
				GPAS_OFS_ADDR: begin
					state_next.rdata[4:0] = state_reg.maj_addr;
					state_next.rdata[12:8] = state_reg.min_addr;
				end
				GPAS_OFS_AUX: begin
					state_next.rdata = 32'h0000_0000;
				end
				GPAS_OFS_LEGA: begin
					state_next.rdata[7:0] = layout_a;
				end
				GPAS_OFS_LEGB: begin
					state_next.rdata[7:0] = layout_b;
				end
				default: begin
					state_next.rresp = GPAS_RESP_SLVERR;
				end
			endcase
		end
		state_next.arready = ~state_next.rvalid;

		// Clearing events are applied first so that sets win.
		if (cmd_ok && is_pcg && !mla) begin
			state_next.listen_primary_addressed = 1'b0;
		end
		if (cmd_ok && is_pcg && !mta) begin
			state_next.speaker_primary_addressed = 1'b0;
		end
		if ((cmd_ok && cb == GPAS_CMD_UNL) || ifc_in ||
			(aux_wr && state_reg.wdata[GPAS_AUX_LUL])) begin
			state_next.la = 1'b0;
		end
		if ((cmd_ok && talk_grp && !mta) || ifc_in ||
			(aux_wr && state_reg.wdata[GPAS_AUX_LUT])) begin
			state_next.ta = 1'b0;
		end
		if (aux_wr && state_reg.wdata[GPAS_AUX_CHRST]) begin
			// Chip reset clears the address LSB.
			state_next.ulpa = 1'b0;
		end
		if (cmd_ok && (mla || mta)) begin
			state_next.ulpa = cb[0];
		end

		if (mode_wr && state_reg.wdata[GPAS_MODE_TON]) begin
			state_next.ta = 1'b1;
			state_next.la = 1'b0;
		end
		if (mode_wr && state_reg.wdata[GPAS_MODE_LON]) begin
			state_next.la = 1'b1;
			state_next.ta = 1'b0;
		end
		if (cmd_ok && mta) begin
			state_next.speaker_primary_addressed = 1'b1;
			state_next.ta = 1'b1;
			state_next.la = 1'b0;
			state_next.listen_primary_addressed = 1'b0;
			state_next.major_minor_select = mta_min & ~mta_maj;
		end
		if (cmd_ok && mla) begin
			state_next.listen_primary_addressed = 1'b1;
			state_next.la = 1'b1;
			state_next.ta = 1'b0;
			state_next.speaker_primary_addressed = 1'b0;
			state_next.major_minor_select = mla_min & ~mla_maj;
		end
		// Select and single flags keep one function.
		if (!dual) begin
			state_next.major_minor_select = 1'b0;
		end
		state_next.la_out = state_next.la;
		state_next.ta_out = state_next.ta | state_next.spas;
	end

	// ----------------------------------------------------------------
	// State register; reset stands for power-on.
	// ----------------------------------------------------------------

	// Register the state; reset clears every flag except awready, wready and arready, which it sets.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= '0;
			state_reg.mode <= GPAS_MODE_RST;
			state_reg.maj_addr <= GPAS_ADDR_RST;
			state_reg.min_addr <= GPAS_ADDR_RST;
			state_reg.awready <= 1'b1;
			state_reg.wready <= 1'b1;
			state_reg.arready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from state flip-flops.
	assign s_axi_awready_out = state_reg.awready;
	assign s_axi_wready_out = state_reg.wready;
	assign s_axi_bvalid_out = state_reg.bvalid;
	assign s_axi_bresp_out = state_reg.bresp;
	assign s_axi_arready_out = state_reg.arready;
	assign s_axi_rvalid_out = state_reg.rvalid;
	assign s_axi_rdata_out = state_reg.rdata;
	assign s_axi_rresp_out = state_reg.rresp;
	assign s_axi_rready_unused_out = state_reg.atn;
	assign listener_active_out = state_reg.la_out;
	assign transmitter_role_active_out = state_reg.ta_out;

endmodule // gpas_status

// >>> testbench/gpas_status_sva.sv
// Checker of flag clearing and read timing of the status bank.
`timescale 1ns/1ps
module gpas_sva (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [gpas_pkg::GPAS_AW-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic atn_in,
	input wire logic ifc_in,
	input wire logic acds_in,
	input wire logic [7:0] cmd_byte_in,
	input wire logic serial_poll_active_in,
	input wire logic listener_active_out,
	input wire logic transmitter_role_active_out
);
	import gpas_pkg::*;
	// Short names of the two role flags.
	wire logic la_w = listener_active_out;
	wire logic ta_w = transmitter_role_active_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Unlisten command, interface clear and read address steps.
	sequence s_unl; acds_in && atn_in && cmd_byte_in[6:0] == GPAS_CMD_UNL;
	endsequence
	sequence s_ifc; (ifc_in && !acds_in) [*2]; endsequence
	sequence s_ar; s_axi_arvalid_in && s_axi_arready_out; endsequence
	// Flag relations and read channel timing.
	property p_unl; s_unl |-> ##[1:2] !la_w; endproperty
	a_unl: assert property (p_unl) else $error("listener kept");
	property p_ifcl; s_ifc |=> !la_w; endproperty
	a_ifcl: assert property (p_ifcl) else $error("listener kept");
	property p_ifct; s_ifc |=> !ta_w || $past(serial_poll_active_in);
	endproperty
	a_ifct: assert property (p_ifct) else $error("talker kept");
	property p_spas; serial_poll_active_in |=> ta_w; endproperty
	a_spas: assert property (p_spas) else $error("poll not talker");
	property p_one;
		$stable(la_w) && $stable(ta_w) && !$past(serial_poll_active_in)
			|-> !(la_w && ta_w);
	endproperty
	a_one: assert property (p_one) else $error("two roles");
	property p_rlat; s_ar |=> s_axi_rvalid_out; endproperty
	a_rlat: assert property (p_rlat) else $error("read late");
	property p_rref; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
	a_rref: assert property (p_rref) else $error("ar accepted");
	property p_bad; s_ar ##0 s_axi_araddr_in > GPAS_OFS_LEGB
		|=> s_axi_rresp_out == GPAS_RESP_SLVERR && s_axi_rdata_out == 32'h0;
	endproperty
	a_bad: assert property (p_bad) else $error("unmapped read");
endmodule // gpas_sva
bind gpas_status gpas_sva gpas_sva_inst (.*);

// >>> testbench/gpas_cic.sv
// Model of the bus controller sending commands and clears.
`timescale 1ns/1ps
module gpas_cic (
	input wire logic clk_in,
	output logic atn_out = 1'b0,
	output logic acds_out = 1'b0,
	output logic ifc_out = 1'b0,
	output logic [7:0] cmd_out = 8'h00
);
	logic hold = 1'b0;
	// Attention, then a one-cycle accept, then accept dropped, attention set to hold and the byte inverted.
	task send(input logic [7:0] b);
		@(posedge clk_in);
		atn_out <= 1'b1;
		cmd_out <= b;
		@(posedge clk_in);
		acds_out <= 1'b1;
		@(posedge clk_in);
		acds_out <= 1'b0;
		atn_out <= hold;
		cmd_out <= ~b;
	endtask
	// Interface clear held for two cycles.
	task clear;
		@(posedge clk_in);
		ifc_out <= 1'b1;
		repeat (2) @(posedge clk_in);
		ifc_out <= 1'b0;
	endtask
endmodule // gpas_cic

// >>> testbench/gpas_status_tb.sv
// Self-checking bench of the address status bank.
`timescale 1ns/1ps
module gpas_status_tb;
	import gpas_pkg::*;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic clk_in, rst_in = 1'b1, serial_poll_mode_in = 1'b0;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
	logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
	logic s_axi_rready_in = 1'b0, serial_poll_active_in = 1'b0;
	logic host_controlled_in = 1'b0, lockout_in = 1'b0;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, d;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_unused_out;
	logic atn_in, ifc_in, acds_in, listener_active_out;
	logic transmitter_role_active_out;
	logic [7:0] cmd_byte_in;
	int mismatches = 0, compares = 0;
	gpas_status gpas_status_inst (.*);
	gpas_cic gpas_cic_inst (
		.clk_in,
		.atn_out(atn_in),
		.acds_out(acds_in),
		.ifc_out(ifc_in),
		.cmd_out(cmd_byte_in)
	);
	// Clock of 100 ns period.
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// Compares a seen value with the expected one.
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Prints the verdict and stops.
	task end_sim;
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// A wait that ran out of cycles.
	task tmo;
		mismatches++;
		$display("[ERR] %0t timeout", $time);
		end_sim;
	endtask
	// Write cycle: address and data offered together, each released when taken.
	task wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		// Let an edge pass so a release never meets the next request.
		@(posedge clk_in);
		n = 0;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while ((s_axi_awvalid_in && !s_axi_awready_out ||
			s_axi_wvalid_in && !s_axi_wready_out) && n < 50);
		do begin
			@(posedge clk_in);
			n++;
		end while (!s_axi_bvalid_out && n < 99);
		if (n >= 99) tmo;
		r = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
	endtask
	// Read cycle: data and response taken at the handshake edge.
	task rd(input logic [7:0] a);
		int n;
		// Let an edge pass so a release never meets the next request.
		@(posedge clk_in);
		n = 0;
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (!s_axi_arready_out && n < 50);
		s_axi_arvalid_in <= 1'b0;
		do begin
			@(posedge clk_in);
			n++;
		end while (!s_axi_rvalid_out && n < 99);
		if (n >= 99) tmo;
		d = s_axi_rdata_out;
		r = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
	endtask
	// Short helpers: one command, masked read check, role flag check.
	task sd(input logic [7:0] b);
		gpas_cic_inst.send(b);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(d & m, e);
	endtask
	task fl(input logic [1:0] e);
		repeat (3) @(posedge clk_in);
		chk({30'h0, listener_active_out, transmitter_role_active_out}, 32'(e));
	endtask
	// Values after reset.
	task t_rst;
		rc(GPAS_OFS_MODE, ALL, 32'h0);
		rc(GPAS_OFS_COND, ALL, 32'h40);
		fl(2'b00);
	endtask
	// Addressing by commands, role swaps and clears.
	task t_addr;
		wr(GPAS_OFS_ADDR, 32'h0905);
		wr(GPAS_OFS_MODE, 32'(GPAS_AM_DUAL));
		sd(8'h25);
		fl(2'b10);
		rc(GPAS_OFS_LEGA, ALL, 32'h54);
		sd(8'h45);
		fl(2'b01);
		rc(GPAS_OFS_LEGA, ALL, 32'h4a);
		sd(8'h29);
		rc(GPAS_OFS_LEGA, 32'h7, 32'h5);
		wr(GPAS_OFS_MODE, 32'(GPAS_AM_SINGLE));
		rc(GPAS_OFS_LEGA, 32'h1, 32'h0);
		wr(GPAS_OFS_MODE, 32'(GPAS_AM_DUAL));
		sd(8'h29);
		sd(8'h45);
		rc(GPAS_OFS_LEGA, 32'h7, 32'h2);
		wr(GPAS_OFS_MODE, 32'(GPAS_AM_EXT_DUAL));
		sd(8'h29);
		rc(GPAS_OFS_LEGA, 32'h7, 32'h5);
		wr(GPAS_OFS_MODE, 32'(GPAS_AM_EXT_SINGLE));
		rc(GPAS_OFS_LEGA, 32'h1, 32'h0);
		wr(GPAS_OFS_MODE, 32'(GPAS_AM_DUAL));
		sd(8'h29);
		sd(8'h3f);
		fl(2'b00);
		sd(8'h49);
		sd(8'h47);
		fl(2'b00);
		sd(8'h25);
		gpas_cic_inst.clear;
		fl(2'b00);
		sd(8'h25);
		wr(GPAS_OFS_AUX, 32'h1);
		fl(2'b00);
		sd(8'h45);
		wr(GPAS_OFS_AUX, 32'h2);
		fl(2'b00);
	endtask
	// Listen-only, speak-only, second layout and chip reset.
	task t_mode;
		wr(GPAS_OFS_MODE, 32'h6);
		fl(2'b10);
		wr(GPAS_OFS_MODE, 32'ha);
		fl(2'b01);
		wr(GPAS_OFS_MODE, 32'h12);
		for (int i = 0; i < 4; i++) begin
			host_controlled_in <= i[1];
			lockout_in <= i[0];
			repeat (2) @(posedge clk_in);
			rc(GPAS_OFS_COND, 32'hc0, 32'(i) << 6);
		end
		gpas_cic_inst.hold = 1'b1;
		sd(8'h25);
		chk({31'h0, s_axi_rready_unused_out}, 32'h1);
		rc(GPAS_OFS_COND, ALL, 32'hf5);
		rc(GPAS_OFS_LEGA, 32'h40, 32'h0);
		wr(GPAS_OFS_MODE, 32'h2);
		rc(GPAS_OFS_COND, ALL, 32'h14);
		wr(GPAS_OFS_AUX, 32'h4);
		rc(GPAS_OFS_LEGB, 32'h1, 32'h0);
	endtask
	// Unmapped places and the serial poll talker.
	task t_bus;
		rd(8'h40);
		chk(32'(r), 32'(GPAS_RESP_SLVERR));
		wr(8'h40, 32'h6);
		chk(32'(r), 32'(GPAS_RESP_SLVERR));
		sd(8'h3f);
		rc(GPAS_OFS_AUX, ALL, 32'h0);
		serial_poll_active_in <= 1'b1;
		fl(2'b01);
		serial_poll_active_in <= 1'b0;
	endtask
	// Main sequence.
	initial begin
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		t_rst;
		t_addr;
		t_mode;
		t_bus;
		end_sim;
	end
endmodule // gpas_status_tb
